// [core/lcc_pkg.sv]
// Shared constants for the logic cluster model
package lcc_pkg;

  // Structure of the cluster
  localparam int N_CELLS = 8;
  localparam int N_LINES = 3;
  localparam int N_ROW = 6;
  localparam int ROUTE_W = 16;
  localparam int LINK_W = 8;

  // Local interconnect pool: row clocks, cell local drives, routing, left and right links
  localparam int POOL_ROW = 0;
  localparam int POOL_CLOCAL = 6;
  localparam int POOL_ROUTE = 22;
  localparam int POOL_LEFT = 38;
  localparam int POOL_RIGHT = 46;
  localparam int POOL_W = 54;
  localparam logic [5:0] SEL_NONE = 6'h3f;

  // Register byte offsets
  localparam logic [11:0] OFF_CLK = 12'h000;
  localparam logic [11:0] OFF_CE = 12'h004;
  localparam logic [11:0] OFF_CTL = 12'h008;
  localparam logic [11:0] OFF_SLOAD = 12'h00c;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [3:0] REGION_CELL = 4'h1;

  // Word index inside a cell's 32-byte window
  localparam logic [2:0] W_LUT0_LO = 3'h0;
  localparam logic [2:0] W_LUT0_HI = 3'h1;
  localparam logic [2:0] W_LUT1_LO = 3'h2;
  localparam logic [2:0] W_LUT1_HI = 3'h3;
  localparam logic [2:0] W_INSEL_LO = 3'h4;
  localparam logic [2:0] W_INSEL_HI = 3'h5;
  localparam logic [2:0] W_REGCFG = 3'h6;
  localparam logic [2:0] W_MODE = 3'h7;

  // Field positions in the cluster words
  localparam int CLK_SRCB_POS = 8;
  localparam int CLK_LINE_POS = 16;
  localparam int CLK_EDGE_POS = 20;
  localparam int CE_USE_POS = 24;
  localparam int CTL_ACLR1_POS = 8;
  localparam int CTL_SCLR_POS = 16;
  localparam int CTL_ALOAD_POS = 24;
  localparam int ST_CE0_LOST_POS = 16;
  localparam int ST_COUNT_POS = 20;

  // Per-register configuration field positions
  localparam int RC_W = 10;
  localparam int RC_CLK_POS = 0;
  localparam int RC_DSRC_POS = 2;
  localparam int RC_ACLR_POS = 4;
  localparam int RC_ALOAD = 6;
  localparam int RC_AFROM_F = 7;
  localparam int RC_SCLR = 8;
  localparam int RC_SLOAD = 9;
  localparam logic [1:0] CLK_NONE = 2'h3;
  localparam logic [1:0] DSRC_COMB = 2'h0;
  localparam logic [1:0] DSRC_PACK = 2'h1;
  localparam logic [1:0] DSRC_CHAIN = 2'h2;
  localparam logic [1:0] ACLR_SEL0 = 2'h1;
  localparam logic [1:0] ACLR_SEL1 = 2'h2;

  // Cell mode bits and cell input order
  localparam int MODE_W = 5;
  localparam int M_EXT = 0;
  localparam int M_FB0 = 1;
  localparam int M_FB1 = 2;
  localparam int M_LOC0_REG = 3;
  localparam int M_LOC1_REG = 4;
  localparam int IN_A = 0;
  localparam int IN_E0 = 4;
  localparam int IN_F0 = 5;
  localparam int IN_E1 = 6;
  localparam int IN_F1 = 7;

  // Values after reset
  localparam logic [31:0] RST_CLK = 32'h00000000;
  localparam logic [31:0] RST_CE = 32'h00000000;
  localparam logic [31:0] RST_CTL = 32'h3f3f3f3f;
  localparam logic [31:0] RST_SLOAD = 32'h0000003f;

endpackage : lcc_pkg

// [core/lcc_cluster.sv]
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module lcc_cluster (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Row clock lines, asynchronous to i_clock
  input wire logic [lcc_pkg::N_ROW-1:0] i_row_clock,
  // Routing and direct links, same clock domain
  input wire logic [lcc_pkg::ROUTE_W-1:0] i_routing,
  input wire logic [lcc_pkg::LINK_W-1:0] i_left_link,
  input wire logic [lcc_pkg::LINK_W-1:0] i_right_link,
  input wire logic [1:0] i_chain_in,
  // Cell outputs
  output logic [15:0] o_cell_comb,
  output logic [15:0] o_cell_reg,
  output logic [15:0] o_cell_local,
  output logic [1:0] o_chain_out
);

  typedef struct packed {
    logic [lcc_pkg::N_ROW-1:0] row_s1;
    logic [lcc_pkg::N_ROW-1:0] row_s2;
    logic [lcc_pkg::N_LINES-1:0] lvl_q;
    logic [31:0] clk_cfg;
    logic [31:0] ce_cfg;
    logic [31:0] ctl_cfg;
    logic [31:0] sload_cfg;
    logic [7:0][1:0][63:0] lut;
    logic [7:0][7:0][5:0] insel;
    logic [7:0][1:0][lcc_pkg::RC_W-1:0] rcfg;
    logic [7:0][lcc_pkg::MODE_W-1:0] mode;
    logic [7:0][1:0] q;
    logic [7:0][1:0] comb_q;
    logic [7:0][1:0] loc_q;
    logic [31:0] rdata_q;
    logic err_q;
  } lcc_state_t;

  lcc_state_t s_q;
  lcc_state_t s_d;

  // Bit of the local pool, or inactive for an unused selector
  function automatic logic lcc_pick(input logic [lcc_pkg::POOL_W-1:0] pool,
                                    input logic [5:0] idx);
    lcc_pick = (int'(idx) < lcc_pkg::POOL_W) ? pool[idx] : 1'b0;
  endfunction : lcc_pick

  // Byte-lane merge for APB writes
  function automatic logic [31:0] lcc_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    lcc_merge = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        lcc_merge[8*b +: 8] = new_w[8*b +: 8];
      end
    end
  endfunction : lcc_merge

  logic [lcc_pkg::POOL_W-1:0] pool;
  logic [lcc_pkg::N_LINES-1:0] lvl;
  logic [lcc_pkg::N_LINES-1:0] edge_hit;
  logic [lcc_pkg::N_LINES-1:0] ce;
  logic [lcc_pkg::N_LINES-1:0] tick;
  logic [lcc_pkg::N_LINES-1:0] line_used;
  logic [1:0] aclr;
  logic sclr;
  logic aload;
  logic sload;
  logic aload_used;
  logic [7:0] cin;
  logic [5:0] src;
  logic t0;
  logic t1;
  logic [1:0] comb;
  logic [1:0] cl;
  logic [1:0] ds;
  logic [1:0] ac;
  logic pk_e;
  logic pk_f;
  logic dval;
  logic tk;
  logic clr_hit;
  logic acc;
  logic setup;
  logic mapped;
  logic [2:0] cidx;
  logic [2:0] widx;
  logic [31:0] rword;
  logic [31:0] wword;
  logic [3:0] ctl_count;

  // APB handshake: zero wait states, answer in the access cycle
  assign acc = i_psel & i_penable;
  assign setup = i_psel & ~i_penable;
  assign o_pready = acc;
  assign o_pslverr = acc & s_q.err_q;
  assign o_prdata = s_q.rdata_q;

  // Cell outputs come straight from state
  assign o_cell_comb = s_q.comb_q;
  assign o_cell_reg = s_q.q;
  assign o_cell_local = s_q.loc_q;
  assign o_chain_out = s_q.q[7];

  // Local pool: only synced row clocks and registered local drives avoid loops
  assign pool = {i_right_link, i_left_link, i_routing, s_q.loc_q, s_q.row_s2};

  // Next-state logic for the whole cluster
  always_comb
  begin
    s_d = s_q;
    src = 6'h00;
    t0 = 1'b0;
    t1 = 1'b0;
    comb = 2'h0;
    cin = 8'h00;
    cl = 2'h0;
    ds = 2'h0;
    ac = 2'h0;
    pk_e = 1'b0;
    pk_f = 1'b0;
    dval = 1'b0;
    tk = 1'b0;
    clr_hit = 1'b0;
    rword = 32'h00000000;
    wword = 32'h00000000;
    // Row clocks cross in through two flops
    s_d.row_s1 = i_row_clock;
    s_d.row_s2 = s_q.row_s1;
    // Asynchronous load borrows the enable-zero line while in use
    aload_used = 1'b0;
    line_used = 3'h0;
    for (int c = 0; c < lcc_pkg::N_CELLS; c++)
    begin
      for (int r = 0; r < 2; r++)
      begin
        aload_used = aload_used | s_q.rcfg[c][r][lcc_pkg::RC_ALOAD];
        cl = s_q.rcfg[c][r][lcc_pkg::RC_CLK_POS +: 2];
        if (cl != lcc_pkg::CLK_NONE)
        begin
          line_used[cl] = 1'b1;
        end
      end
    end
    // Three lines choose between only two sources, each with its own edge
    for (int k = 0; k < lcc_pkg::N_LINES; k++)
    begin
      src = s_q.clk_cfg[lcc_pkg::CLK_LINE_POS + k] ?
            s_q.clk_cfg[lcc_pkg::CLK_SRCB_POS +: 6] : s_q.clk_cfg[5:0];
      lvl[k] = lcc_pick(pool, src);
      edge_hit[k] = s_q.clk_cfg[lcc_pkg::CLK_EDGE_POS + k] ?
                    (s_q.lvl_q[k] & ~lvl[k]) : (~s_q.lvl_q[k] & lvl[k]);
      ce[k] = s_q.ce_cfg[lcc_pkg::CE_USE_POS + k] ?
              lcc_pick(pool, s_q.ce_cfg[6*k +: 6]) : 1'b1;
      tick[k] = edge_hit[k] & ce[k];
    end
    if (aload_used)
    begin
      ce[0] = 1'b1;
      tick[0] = edge_hit[0];
    end
    s_d.lvl_q = lvl;
    // Remaining cluster-wide controls
    aclr[0] = lcc_pick(pool, s_q.ctl_cfg[5:0]);
    aclr[1] = lcc_pick(pool, s_q.ctl_cfg[lcc_pkg::CTL_ACLR1_POS +: 6]);
    sclr = lcc_pick(pool, s_q.ctl_cfg[lcc_pkg::CTL_SCLR_POS +: 6]);
    aload = lcc_pick(pool, s_q.ctl_cfg[lcc_pkg::CTL_ALOAD_POS +: 6]);
    sload = lcc_pick(pool, s_q.sload_cfg[5:0]);
    // Controls in use, never above eleven
    ctl_count = 4'(line_used[0]) + 4'(line_used[1]) + 4'(line_used[2])
              + 4'(s_q.ce_cfg[lcc_pkg::CE_USE_POS]) + 4'(s_q.ce_cfg[lcc_pkg::CE_USE_POS + 1])
              + 4'(s_q.ce_cfg[lcc_pkg::CE_USE_POS + 2])
              + 4'(s_q.ctl_cfg[5:0] != lcc_pkg::SEL_NONE)
              + 4'(s_q.ctl_cfg[lcc_pkg::CTL_ACLR1_POS +: 6] != lcc_pkg::SEL_NONE)
              + 4'(s_q.ctl_cfg[lcc_pkg::CTL_SCLR_POS +: 6] != lcc_pkg::SEL_NONE)
              + 4'(s_q.ctl_cfg[lcc_pkg::CTL_ALOAD_POS +: 6] != lcc_pkg::SEL_NONE)
              + 4'(s_q.sload_cfg[5:0] != lcc_pkg::SEL_NONE);
    // Eight logic cells
    for (int c = 0; c < lcc_pkg::N_CELLS; c++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        cin[i] = lcc_pick(pool, s_q.insel[c][i]);
      end
      if (s_q.mode[c][lcc_pkg::M_FB0])
      begin
        cin[lcc_pkg::IN_F0] = s_q.q[c][0];
      end
      if (s_q.mode[c][lcc_pkg::M_FB1])
      begin
        cin[lcc_pkg::IN_F1] = s_q.q[c][1];
      end
      // Two six-input tables sharing inputs a to d
      t0 = s_q.lut[c][0][{cin[lcc_pkg::IN_F0], cin[lcc_pkg::IN_E0], cin[3:0]}];
      t1 = s_q.lut[c][1][{cin[lcc_pkg::IN_F1], cin[lcc_pkg::IN_E1], cin[3:0]}];
      // Extended mode muxes both tables into one eight-input function
      comb[0] = s_q.mode[c][lcc_pkg::M_EXT] ? (cin[lcc_pkg::IN_F1] ? t1 : t0) : t0;
      comb[1] = t1;
      for (int r = 0; r < 2; r++)
      begin
        cl = s_q.rcfg[c][r][lcc_pkg::RC_CLK_POS +: 2];
        ds = s_q.rcfg[c][r][lcc_pkg::RC_DSRC_POS +: 2];
        ac = s_q.rcfg[c][r][lcc_pkg::RC_ACLR_POS +: 2];
        pk_e = cin[lcc_pkg::IN_E0 + 2*r];
        pk_f = cin[lcc_pkg::IN_F0 + 2*r];
        unique case (ds)
          lcc_pkg::DSRC_PACK: dval = pk_e;
          lcc_pkg::DSRC_CHAIN: dval = (c == 0) ? i_chain_in[r] : s_q.q[c-1][r];
          default: dval = comb[r];
        endcase
        tk = (cl != lcc_pkg::CLK_NONE) ? tick[cl] : 1'b0;
        clr_hit = ((ac == lcc_pkg::ACLR_SEL0) & aclr[0]) | ((ac == lcc_pkg::ACLR_SEL1) & aclr[1]);
        // Clear first, then asynchronous load, then clocked controls
        if (clr_hit)
        begin
          s_d.q[c][r] = 1'b0;
        end
        else if (s_q.rcfg[c][r][lcc_pkg::RC_ALOAD] & aload)
        begin
          s_d.q[c][r] = s_q.rcfg[c][r][lcc_pkg::RC_AFROM_F] ? pk_f : pk_e;
        end
        else if (tk)
        begin
          if (s_q.rcfg[c][r][lcc_pkg::RC_SCLR] & sclr)
          begin
            s_d.q[c][r] = 1'b0;
          end
          else if (s_q.rcfg[c][r][lcc_pkg::RC_SLOAD] & sload)
          begin
            s_d.q[c][r] = pk_f;
          end
          else
          begin
            s_d.q[c][r] = dval;
          end
        end
        // Table result, taken through its own flop, leaves beside the register value
        s_d.comb_q[c][r] = comb[r];
        s_d.loc_q[c][r] = s_q.mode[c][lcc_pkg::M_LOC0_REG + r] ? s_q.q[c][r] : comb[r];
      end
    end
    // Register decode
    cidx = i_paddr[7:5];
    widx = i_paddr[4:2];
    mapped = 1'b1;
    if (i_paddr[11:8] == lcc_pkg::REGION_CELL)
    begin
      unique case (widx)
        lcc_pkg::W_LUT0_LO: rword = s_q.lut[cidx][0][31:0];
        lcc_pkg::W_LUT0_HI: rword = s_q.lut[cidx][0][63:32];
        lcc_pkg::W_LUT1_LO: rword = s_q.lut[cidx][1][31:0];
        lcc_pkg::W_LUT1_HI: rword = s_q.lut[cidx][1][63:32];
        lcc_pkg::W_INSEL_LO: rword = {8'h00, s_q.insel[cidx][3:0]};
        lcc_pkg::W_INSEL_HI: rword = {8'h00, s_q.insel[cidx][7:4]};
        lcc_pkg::W_REGCFG: rword = {6'h00, s_q.rcfg[cidx][1], 6'h00, s_q.rcfg[cidx][0]};
        lcc_pkg::W_MODE: rword = {27'h0000000, s_q.mode[cidx]};
      endcase
    end
    else
    begin
      unique case ({i_paddr[11:2], 2'h0})
        lcc_pkg::OFF_CLK: rword = s_q.clk_cfg;
        lcc_pkg::OFF_CE: rword = s_q.ce_cfg;
        lcc_pkg::OFF_CTL: rword = s_q.ctl_cfg;
        lcc_pkg::OFF_SLOAD: rword = s_q.sload_cfg;
        lcc_pkg::OFF_STATUS: rword = {8'h00, ctl_count, 3'h0, aload_used, s_q.q};
        default: mapped = 1'b0;
      endcase
    end
    // Read data and error captured in setup, shown in access
    if (setup)
    begin
      s_d.rdata_q = mapped ? rword : 32'h00000000;
      s_d.err_q = ~mapped;
    end
    // Writes take effect at the access edge; status ignores writes
    wword = lcc_merge(rword, i_pwdata, i_pstrb);
    if (acc & i_pwrite & mapped)
    begin
      if (i_paddr[11:8] == lcc_pkg::REGION_CELL)
      begin
        unique case (widx)
          lcc_pkg::W_LUT0_LO: s_d.lut[cidx][0][31:0] = wword;
          lcc_pkg::W_LUT0_HI: s_d.lut[cidx][0][63:32] = wword;
          lcc_pkg::W_LUT1_LO: s_d.lut[cidx][1][31:0] = wword;
          lcc_pkg::W_LUT1_HI: s_d.lut[cidx][1][63:32] = wword;
          lcc_pkg::W_INSEL_LO: s_d.insel[cidx][3:0] = wword[23:0];
          lcc_pkg::W_INSEL_HI: s_d.insel[cidx][7:4] = wword[23:0];
          lcc_pkg::W_REGCFG:
          begin
            s_d.rcfg[cidx][0] = wword[lcc_pkg::RC_W-1:0];
            s_d.rcfg[cidx][1] = wword[16 +: lcc_pkg::RC_W];
          end
          lcc_pkg::W_MODE: s_d.mode[cidx] = wword[lcc_pkg::MODE_W-1:0];
        endcase
      end
      else
      begin
        unique case ({i_paddr[11:2], 2'h0})
          lcc_pkg::OFF_CLK: s_d.clk_cfg = wword;
          lcc_pkg::OFF_CE: s_d.ce_cfg = wword;
          lcc_pkg::OFF_CTL: s_d.ctl_cfg = wword;
          lcc_pkg::OFF_SLOAD: s_d.sload_cfg = wword;
          default: s_d.err_q = s_q.err_q;
        endcase
      end
    end
  end

  // State register; input and control selectors reset to the unused code, clock and enable selectors to zero
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      s_q <= '0;
      s_q.clk_cfg <= lcc_pkg::RST_CLK;
      s_q.ce_cfg <= lcc_pkg::RST_CE;
      s_q.ctl_cfg <= lcc_pkg::RST_CTL;
      s_q.sload_cfg <= lcc_pkg::RST_SLOAD;
      s_q.insel <= '1;
      s_q.rcfg <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : lcc_cluster

`default_nettype wire

// [tb/lcc_neighbour.sv]
`timescale 1ns/100ps
`default_nettype none

module lcc_neighbour (
  // Clock and burst control
  input wire logic i_clock,
  input wire logic i_run,
  // Drives toward the cluster
  output logic [5:0] o_row_clock,
  output logic [7:0] o_left_link,
  output logic [7:0] o_right_link
);
  logic [7:0] cnt_q;

  // Burst counter, parked at zero between bursts so the row clock stands still
  always_ff @(posedge i_clock)
  begin
    if (!i_run)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end

  // Row clock 0 rises once every 16 cycles of a burst, low outside it
  assign o_row_clock = i_run ? {5'h00, cnt_q[3]} : 6'h00;
  // Neighbour cells change their outputs during a burst so nothing stale looks valid
  assign o_left_link = cnt_q ^ 8'h5a;
  assign o_right_link = ~cnt_q;
endmodule : lcc_neighbour

`default_nettype wire

// [tb/lcc_checker.sv]
`timescale 1ns/100ps
`default_nettype none

module lcc_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Fabric
  input wire logic [lcc_pkg::N_ROW-1:0] i_row_clock,
  input wire logic [lcc_pkg::ROUTE_W-1:0] i_routing,
  input wire logic [lcc_pkg::LINK_W-1:0] i_left_link,
  input wire logic [lcc_pkg::LINK_W-1:0] i_right_link,
  input wire logic [1:0] i_chain_in,
  input wire logic [15:0] o_cell_comb,
  input wire logic [15:0] o_cell_reg,
  input wire logic [15:0] o_cell_local,
  input wire logic [1:0] o_chain_out
);
  logic [39:0] fab_now;
  logic [39:0] fab_q;
  logic [3:0] quiet_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  assign fab_now = {i_row_clock, i_routing, i_left_link, i_right_link, i_chain_in};

  // Cycles with no fabric change and no bus traffic; synchronisers need time to drain
  always_ff @(posedge i_clock)
  begin
    fab_q <= fab_now;
    if (i_rst || i_psel || fab_now != fab_q)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hf)
      quiet_q <= quiet_q + 4'h1;
  end

  a_ready_access: assert property (o_pready == (i_psel && i_penable))
    else $error("pready not tied to access phase");
  a_err_in_access: assert property (o_pslverr |-> (i_psel && i_penable))
    else $error("pslverr outside access phase");
  a_unmapped_err: assert property ((i_psel && !i_penable && i_paddr[1:0] == 2'h0 &&
    ((i_paddr > 12'h010 && i_paddr < 12'h100) || i_paddr >= 12'h200))
    |=> (o_pslverr && o_prdata == 32'h0))
    else $error("unmapped access not refused");
  a_reset_clear: assert property ($fell(i_rst) |-> (o_cell_reg == 16'h0 &&
    o_cell_local == 16'h0 && o_chain_out == 2'h0))
    else $error("cell outputs not cleared by reset");
  a_hold_quiet: assert property ((quiet_q >= 4'h6) |-> $stable(o_cell_reg))
    else $error("register changed with no qualifying event");
  a_local_source: assert property (((o_cell_local ^ o_cell_comb) & (o_cell_local ^ o_cell_reg)
    & (o_cell_local ^ $past(o_cell_reg))) == 16'h0)
    else $error("local drive matches neither table nor register");
  a_chain_tail: assert property (o_chain_out == o_cell_reg[15:14])
    else $error("chain output differs from last cell registers");
  a_status_regs: assert property ((i_psel && !i_penable && i_paddr == lcc_pkg::OFF_STATUS)
    |=> o_prdata[15:0] == $past(o_cell_reg))
    else $error("status does not show the cell registers");

  c_refused: cover property (o_pslverr);
  c_chain_moves: cover property ($changed(o_chain_out));
  c_quiet_held: cover property (quiet_q == 4'hf && o_cell_reg != 16'h0);
endmodule : lcc_checker

bind lcc_cluster lcc_checker u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_row_clock(i_row_clock), .i_routing(i_routing),
  .i_left_link(i_left_link), .i_right_link(i_right_link), .i_chain_in(i_chain_in),
  .o_cell_comb(o_cell_comb), .o_cell_reg(o_cell_reg), .o_cell_local(o_cell_local),
  .o_chain_out(o_chain_out));

`default_nettype wire

// [tb/lcc_cluster_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module lcc_cluster_tb;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, run, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0] pstrb;
  logic [5:0] row_clock;
  logic [15:0] routing, comb, regs, local_drv, exp_q;
  logic [7:0] left_link, right_link;
  logic [1:0] chain_in, chain_out;
  int fail_count, compares, cycles;
  logic [11:0] offs [4] = '{lcc_pkg::OFF_CLK, lcc_pkg::OFF_CE, lcc_pkg::OFF_CTL, lcc_pkg::OFF_SLOAD};
  logic [31:0] rstv [4] = '{lcc_pkg::RST_CLK, lcc_pkg::RST_CE, lcc_pkg::RST_CTL, lcc_pkg::RST_SLOAD};

  lcc_cluster DUT (.i_clock(clock), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_row_clock(row_clock), .i_routing(routing),
    .i_left_link(left_link), .i_right_link(right_link), .i_chain_in(chain_in),
    .o_cell_comb(comb), .o_cell_reg(regs), .o_cell_local(local_drv), .o_chain_out(chain_out));

  lcc_neighbour u_nb (.i_clock(clock), .i_run(run), .o_row_clock(row_clock),
    .o_left_link(left_link), .o_right_link(right_link));

  // Free-running 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bus

  task automatic chk_cells(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cells

  // One APB transfer; waits for pready rather than assuming zero wait states
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // Only the hang guard ends a wait that never sees pready
    while (pready !== 1'b1)
    begin
      @(posedge clock);
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] cell_addr(int c, logic [2:0] w);
    return 12'h100 + 12'(c * 32) + {7'h0, w, 2'h0};
  endfunction : cell_addr

  function automatic logic [15:0] shifted(logic [15:0] v, logic [1:0] c);
    return {v[13:0], c};
  endfunction : shifted

  // One half period of routing[0]; chain input changes only in halves without a tick
  task automatic half(input logic lvl, input logic moves);
    @(posedge clock);
    routing[0] <= lvl;
    if (!moves)
      chain_in <= 2'($urandom);
    repeat (5) @(posedge clock);
    if (moves)
      exp_q = shifted(exp_q, chain_in);
    chk_cells(regs, exp_q);
  endtask : half

  // Step one routing line and let the asynchronous controls settle
  task automatic drive(input int i, input logic v);
    @(posedge clock);
    routing[i] <= v;
    repeat (4) @(posedge clock);
  endtask : drive

  initial
  begin
    {psel, penable, pwrite, run, err_q} = '0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    routing = 16'h0;
    chain_in = 2'h0;
    exp_q = 16'h0;
    rst = 1'b1;
    void'($urandom(32'h517a));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Reset values, then refused places
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      chk_bus(rd_q, rstv[i]);
    end
    apb(1'b0, 12'h014, 32'h0);
    chk_bus({31'h0, err_q}, 32'h1);
    apb(1'b1, 12'h200, $urandom);
    chk_bus({31'h0, err_q}, 32'h1);
    // Every register takes the chain from its neighbour, clocked by routing[0]
    apb(1'b1, lcc_pkg::OFF_CLK, 32'h00000016);
    for (int c = 0; c < 8; c++)
      apb(1'b1, cell_addr(c, lcc_pkg::W_REGCFG), 32'h00080008);
    repeat (6)
    begin
      half(1'b1, 1'b1);
      half(1'b0, 1'b0);
    end
    apb(1'b1, lcc_pkg::OFF_CLK, 32'h00100016);
    half(1'b1, 1'b0);
    half(1'b0, 1'b1);
    // Enable 0 fed by routing[1], held low
    apb(1'b1, lcc_pkg::OFF_CLK, 32'h00000016);
    apb(1'b1, lcc_pkg::OFF_CE, 32'h01000017);
    half(1'b1, 1'b0);
    half(1'b0, 1'b0);
    // A low enable 1 must not gate line 0
    apb(1'b1, lcc_pkg::OFF_CE, 32'h020005c0);
    half(1'b1, 1'b1);
    half(1'b0, 1'b0);
    // Asynchronous load in use takes enable 0 away
    apb(1'b1, lcc_pkg::OFF_CE, 32'h01000017);
    apb(1'b1, lcc_pkg::OFF_CTL, 32'h1c3f3f3f);
    // A register that uses the asynchronous load is what puts it in use
    apb(1'b1, cell_addr(0, lcc_pkg::W_REGCFG), 32'h00080048);
    half(1'b1, 1'b1);
    half(1'b0, 1'b0);
    apb(1'b0, lcc_pkg::OFF_STATUS, 32'h0);
    chk_bus(rd_q & 32'h0001ffff, {15'h0000, 1'b1, exp_q});
    // Cell 0 reg 0: load from input e (routing[3]), clear on routing[2]
    apb(1'b1, cell_addr(0, 3'h5), 32'h00000019);
    apb(1'b1, cell_addr(0, lcc_pkg::W_REGCFG), 32'h00080058);
    apb(1'b1, lcc_pkg::OFF_CTL, 32'h1c3f3f18);
    drive(3, 1'b1);
    drive(6, 1'b1);
    exp_q[0] = 1'b1;
    chk_cells(regs, exp_q);
    drive(2, 1'b1);
    exp_q[0] = 1'b0;
    chk_cells(regs, exp_q);
    drive(2, 1'b0);
    exp_q[0] = 1'b1;
    chk_cells(regs, exp_q);
    drive(6, 1'b0);
    chk_cells(regs, exp_q);
    // Row clock 0 from the neighbour: four rising edges in one burst
    apb(1'b1, cell_addr(0, lcc_pkg::W_REGCFG), 32'h00080008);
    apb(1'b1, lcc_pkg::OFF_CTL, lcc_pkg::RST_CTL);
    apb(1'b1, lcc_pkg::OFF_CE, lcc_pkg::RST_CE);
    apb(1'b1, lcc_pkg::OFF_CLK, 32'h00000000);
    @(posedge clock);
    chain_in <= 2'h3;
    run <= 1'b1;
    repeat (64) @(posedge clock);
    run <= 1'b0;
    repeat (8) @(posedge clock);
    repeat (4) exp_q = shifted(exp_q, 2'h3);
    chk_cells(regs, exp_q);
    apb(1'b0, lcc_pkg::OFF_STATUS, 32'h0);
    chk_bus({16'h0, rd_q[15:0]}, {16'h0, exp_q});
    // Table 0 of cell 1 holds a one at index zero; its inputs all read zero
    apb(1'b1, cell_addr(1, lcc_pkg::W_LUT0_LO), 32'h00000001);
    repeat (2) @(posedge clock);
    chk_cells(comb, 16'h0004);
    chk_cells(local_drv, 16'h0004);
    // Local drive of cell 1 set 0 now takes its register
    apb(1'b1, cell_addr(1, lcc_pkg::W_MODE), 32'h00000008);
    repeat (2) @(posedge clock);
    chk_cells(local_drv, {13'h0000, exp_q[2], 2'h0});
    chk_cells(comb, 16'h0004);
    // Cell 0: sync load of input f (routing[3] high) on routing[5], sync clear on routing[4]
    apb(1'b1, lcc_pkg::OFF_CLK, 32'h00000016);
    apb(1'b1, cell_addr(0, 3'h5), 32'h00659659);
    apb(1'b1, cell_addr(0, lcc_pkg::W_REGCFG), 32'h03080308);
    apb(1'b1, lcc_pkg::OFF_SLOAD, 32'h0000001b);
    apb(1'b1, lcc_pkg::OFF_CTL, 32'h3f1a3f3f);
    drive(5, 1'b1);
    chk_cells(regs, exp_q);
    drive(0, 1'b1);
    exp_q = shifted(exp_q, 2'h3);
    chk_cells(regs, exp_q);
    drive(4, 1'b1);
    drive(0, 1'b0);
    drive(0, 1'b1);
    exp_q = shifted(exp_q, 2'h0);
    chk_cells(regs, exp_q);
    conclude();
  end
endmodule : lcc_cluster_tb

`default_nettype wire
